// ### design/nxe_pkg.sv
// Package with opcodes, decode classes and timing figures for the executor
package nxe_pkg;

    // ------------------------------------------------------------------
    // Opcode patterns and masks
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_SWAP_LOW = 8'hd6;
    localparam logic [7:0] MASK_PTR = 8'hfe;
    localparam logic [7:0] OP_XOR_A_REG = 8'h68;
    localparam logic [7:0] MASK_REG = 8'hf8;
    localparam logic [7:0] OP_XOR_A_DIR = 8'h65;
    localparam logic [7:0] OP_XOR_A_IND = 8'h66;
    localparam logic [7:0] OP_XOR_A_IMM = 8'h64;
    localparam logic [7:0] OP_XOR_D_ACC = 8'h62;
    localparam logic [7:0] OP_XOR_D_IMM = 8'h63;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int PTR_SEL_BIT = 0;
    localparam int REG_SEL_MSB = 2;
    localparam int SFR_SPACE_BIT = 7;
    localparam int NIB_HI_MSB = 7;
    localparam int NIB_HI_LSB = 4;
    localparam int NIB_LO_MSB = 3;
    localparam int NIB_LO_LSB = 0;

    // ------------------------------------------------------------------
    // Lengths in bytes and machine cycles
    // ------------------------------------------------------------------
    localparam logic [1:0] LEN_ONE = 2'h1;
    localparam logic [1:0] LEN_TWO = 2'h2;
    localparam logic [1:0] LEN_THREE = 2'h3;
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] LEN_NONE = 2'h0;

    // ------------------------------------------------------------------
    // Decode classes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        K_NONE,
        K_SWAP_LOW,
        K_A_REG,
        K_A_DIR,
        K_A_IND,
        K_A_IMM,
        K_D_ACC,
        K_D_IMM
    } nxe_kind_type;

endpackage

// ### design/nxe_xor_unit.sv
// Byte exclusive-or with even parity of the result
`timescale 1ns/1ps
`default_nettype none
module nxe_xor_unit #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] operand_i,
    input wire logic [WIDTH-1:0] mask_i,
    output logic [WIDTH-1:0] result_o,
    output logic parity_o
);

    // ------------------------------------------------------------------
    // Combine and reduce
    // ------------------------------------------------------------------
    always_comb begin
        result_o = operand_i ^ mask_i; // [RQ3]
        parity_o = ^(operand_i ^ mask_i);
    end

endmodule // nxe_xor_unit
`default_nettype wire

// ### design/nxe_exec.sv
// Executor for the low nibble swap and exclusive-or instruction groups
//
// Contract
// [RQ1] Opcode 1101011i swaps low nibbles through pointer
// [RQ2] Swap keeps high nibbles, touches no flag
// [RQ3] Exclusive-or result goes to destination operand
// [RQ4] Only parity changes, and only for accumulator
// [RQ5] Port destination read from output latch
// [RQ6] Accumulator forms: register, direct, indirect sources
// [RQ7] Six forms; 01100100 XORs immediate into accumulator
// [RQ8] 01100011 direct, immediate: three bytes, two cycles
// [RQ9] Direct destination inverts bits chosen by mask
// [RQ10] 01100010 direct, accumulator: two bytes, one cycle
`timescale 1ns/1ps
`default_nettype none
module nxe_exec (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic start_i,
    input wire logic [7:0] opcode_i,
    input wire logic [7:0] operand1_i,
    input wire logic [7:0] operand2_i,
    input wire logic [1:0] bank_i,
    input wire logic [7:0] acc_i,
    input wire logic [7:0] mem_rdata_i,
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic [7:0] mem_addr_o,
    output logic mem_sfr_o,
    output logic mem_latch_o,
    output logic [7:0] mem_wdata_o,
    output logic acc_wr_o,
    output logic [7:0] acc_wdata_o,
    output logic parity_wr_o,
    output logic parity_o,
    output logic busy_o,
    output logic done_o,
    output logic unsupported_o,
    output logic [1:0] length_o,
    output logic [1:0] cycles_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_POINTER,
        ST_OPERAND
    } nxe_state_type;

    typedef struct packed {
        nxe_state_type state;
        nxe_pkg::nxe_kind_type kind;
        logic [7:0] imm1;
        logic [7:0] imm2;
        logic [7:0] acc;
        logic mem_rd;
        logic mem_wr;
        logic [7:0] mem_addr;
        logic mem_sfr;
        logic mem_latch;
        logic [7:0] mem_wdata;
        logic acc_wr;
        logic [7:0] acc_wdata;
        logic parity_wr;
        logic parity;
        logic busy;
        logic done;
        logic unsupported;
        logic [1:0] length;
        logic [1:0] cycles;
    } nxe_regs_type;

    nxe_regs_type cur;
    nxe_regs_type next_cur;
    logic [7:0] xor_operand;
    logic [7:0] xor_mask;
    logic [7:0] xor_result;
    logic xor_parity;

    // ------------------------------------------------------------------
    // Opcode classification
    // ------------------------------------------------------------------
    function automatic nxe_pkg::nxe_kind_type classify(input logic [7:0] op);
        nxe_pkg::nxe_kind_type k;
        k = nxe_pkg::K_NONE;
        if ((op & nxe_pkg::MASK_PTR) == nxe_pkg::OP_SWAP_LOW) begin
            k = nxe_pkg::K_SWAP_LOW; // [RQ1]
        end else if ((op & nxe_pkg::MASK_REG) == nxe_pkg::OP_XOR_A_REG) begin
            k = nxe_pkg::K_A_REG; // [RQ6]
        end else if (op == nxe_pkg::OP_XOR_A_DIR) begin
            k = nxe_pkg::K_A_DIR; // [RQ6]
        end else if ((op & nxe_pkg::MASK_PTR) == nxe_pkg::OP_XOR_A_IND) begin
            k = nxe_pkg::K_A_IND; // [RQ6]
        end else if (op == nxe_pkg::OP_XOR_A_IMM) begin
            k = nxe_pkg::K_A_IMM; // [RQ7]
        end else if (op == nxe_pkg::OP_XOR_D_ACC) begin
            k = nxe_pkg::K_D_ACC; // [RQ10]
        end else if (op == nxe_pkg::OP_XOR_D_IMM) begin
            k = nxe_pkg::K_D_IMM; // [RQ8]
        end
        return k;
    endfunction

    function automatic logic [1:0] byte_count(input nxe_pkg::nxe_kind_type k);
        logic [1:0] n;
        n = nxe_pkg::LEN_NONE;
        case (k)
            nxe_pkg::K_SWAP_LOW: n = nxe_pkg::LEN_ONE; // [RQ1]
            nxe_pkg::K_A_REG: n = nxe_pkg::LEN_ONE; // [RQ6]
            nxe_pkg::K_A_IND: n = nxe_pkg::LEN_ONE; // [RQ6]
            nxe_pkg::K_A_DIR: n = nxe_pkg::LEN_TWO; // [RQ6]
            nxe_pkg::K_A_IMM: n = nxe_pkg::LEN_TWO; // [RQ7]
            nxe_pkg::K_D_ACC: n = nxe_pkg::LEN_TWO; // [RQ10]
            nxe_pkg::K_D_IMM: n = nxe_pkg::LEN_THREE; // [RQ8]
            default: n = nxe_pkg::LEN_NONE;
        endcase
        return n;
    endfunction

    // ------------------------------------------------------------------
    // Operand selection and arithmetic
    // ------------------------------------------------------------------
    always_comb begin
        if (cur.kind == nxe_pkg::K_A_IMM) begin
            xor_operand = cur.imm1; // [RQ7]
        end else begin
            xor_operand = mem_rdata_i;
        end
        if (cur.kind == nxe_pkg::K_D_IMM) begin
            xor_mask = cur.imm2; // [RQ9]
        end else begin
            xor_mask = cur.acc; // [RQ9]
        end
    end

    nxe_xor_unit #(
        .WIDTH(8)
    ) u_xor (
        .operand_i(xor_operand),
        .mask_i(xor_mask),
        .result_o(xor_result),
        .parity_o(xor_parity)
    );

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        next_cur.mem_rd = 1'b0;
        next_cur.mem_wr = 1'b0;
        next_cur.acc_wr = 1'b0;
        next_cur.parity_wr = 1'b0;
        next_cur.done = 1'b0;
        next_cur.unsupported = 1'b0;
        case (cur.state)
            ST_IDLE: begin
                if (start_i) begin
                    next_cur.kind = classify(opcode_i);
                    next_cur.imm1 = operand1_i;
                    next_cur.imm2 = operand2_i;
                    next_cur.acc = acc_i;
                    next_cur.length = byte_count(classify(opcode_i));
                    next_cur.cycles = nxe_pkg::CYC_ONE;
                    next_cur.mem_sfr = 1'b0;
                    next_cur.mem_latch = 1'b0;
                    next_cur.busy = 1'b1;
                    case (classify(opcode_i))
                        nxe_pkg::K_SWAP_LOW, nxe_pkg::K_A_IND: begin
                            next_cur.mem_rd = 1'b1;
                            next_cur.mem_addr = {3'h0, bank_i, 2'h0,
                                opcode_i[nxe_pkg::PTR_SEL_BIT]}; // [RQ1]
                            next_cur.state = ST_POINTER;
                        end
                        nxe_pkg::K_A_REG: begin
                            next_cur.mem_rd = 1'b1;
                            next_cur.mem_addr = {3'h0, bank_i,
                                opcode_i[nxe_pkg::REG_SEL_MSB:0]}; // [RQ6]
                            next_cur.state = ST_OPERAND;
                        end
                        nxe_pkg::K_A_DIR: begin
                            next_cur.mem_rd = 1'b1;
                            next_cur.mem_addr = operand1_i;
                            next_cur.mem_sfr =
                                operand1_i[nxe_pkg::SFR_SPACE_BIT];
                            next_cur.state = ST_OPERAND;
                        end
                        nxe_pkg::K_D_ACC, nxe_pkg::K_D_IMM: begin
                            next_cur.mem_rd = 1'b1;
                            next_cur.mem_addr = operand1_i;
                            next_cur.mem_sfr =
                                operand1_i[nxe_pkg::SFR_SPACE_BIT];
                            next_cur.mem_latch = 1'b1; // [RQ5]
                            next_cur.state = ST_OPERAND;
                            if (classify(opcode_i) == nxe_pkg::K_D_IMM) begin
                                next_cur.cycles = nxe_pkg::CYC_TWO; // [RQ8]
                            end
                        end
                        nxe_pkg::K_A_IMM: begin
                            next_cur.state = ST_OPERAND; // [RQ7]
                        end
                        default: begin
                            next_cur.busy = 1'b0;
                            next_cur.unsupported = 1'b1;
                            next_cur.state = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_POINTER: begin
                next_cur.mem_rd = 1'b1;
                next_cur.mem_addr = mem_rdata_i; // [RQ1]
                next_cur.mem_sfr = 1'b0;
                next_cur.state = ST_OPERAND;
            end
            ST_OPERAND: begin
                next_cur.done = 1'b1;
                next_cur.busy = 1'b0;
                next_cur.state = ST_IDLE;
                case (cur.kind)
                    nxe_pkg::K_SWAP_LOW: begin
                        next_cur.mem_wr = 1'b1;
                        next_cur.mem_wdata = {
                            mem_rdata_i[nxe_pkg::NIB_HI_MSB:nxe_pkg::NIB_HI_LSB],
                            cur.acc[nxe_pkg::NIB_LO_MSB:nxe_pkg::NIB_LO_LSB]
                        }; // [RQ1] [RQ2]
                        next_cur.acc_wr = 1'b1;
                        next_cur.acc_wdata = {
                            cur.acc[nxe_pkg::NIB_HI_MSB:nxe_pkg::NIB_HI_LSB],
                            mem_rdata_i[nxe_pkg::NIB_LO_MSB:nxe_pkg::NIB_LO_LSB]
                        }; // [RQ1] [RQ2]
                    end
                    nxe_pkg::K_A_REG, nxe_pkg::K_A_DIR,
                    nxe_pkg::K_A_IND, nxe_pkg::K_A_IMM: begin
                        next_cur.acc_wr = 1'b1;
                        next_cur.acc_wdata = xor_result; // [RQ3]
                        next_cur.parity_wr = 1'b1;
                        next_cur.parity = xor_parity; // [RQ4]
                    end
                    nxe_pkg::K_D_ACC, nxe_pkg::K_D_IMM: begin
                        next_cur.mem_wr = 1'b1;
                        next_cur.mem_latch = 1'b0;
                        next_cur.mem_wdata = xor_result; // [RQ3] [RQ9]
                    end
                    default: begin
                        next_cur.done = 1'b0;
                    end
                endcase
            end
            default: begin
                next_cur.state = ST_IDLE;
                next_cur.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_comb begin
        mem_rd_o = cur.mem_rd;
        mem_wr_o = cur.mem_wr;
        mem_addr_o = cur.mem_addr;
        mem_sfr_o = cur.mem_sfr;
        mem_latch_o = cur.mem_latch;
        mem_wdata_o = cur.mem_wdata;
        acc_wr_o = cur.acc_wr;
        acc_wdata_o = cur.acc_wdata;
        parity_wr_o = cur.parity_wr;
        parity_o = cur.parity;
        busy_o = cur.busy;
        done_o = cur.done;
        unsupported_o = cur.unsupported;
        length_o = cur.length;
        cycles_o = cur.cycles;
    end

endmodule // nxe_exec
`default_nettype wire

// ### tb/nxe_mem_model.sv
// Internal RAM and SFR space model with port latch and pin views
`timescale 1ns/1ps
`default_nettype none
module nxe_mem_model (
    input wire logic ref_clk_i,
    input wire logic mem_rd_i,
    input wire logic mem_wr_i,
    input wire logic [7:0] mem_addr_i,
    input wire logic mem_sfr_i,
    input wire logic mem_latch_i,
    input wire logic [7:0] mem_wdata_i,
    output logic [7:0] mem_rdata_o
);
    logic [7:0] mem [512];
    logic [7:0] last = 8'h00;
    // Pins differ from latch; bus shows inverse of last value when idle
    always_comb begin
        if (!mem_rd_i) begin
            mem_rdata_o = ~last;
        end else if (mem_sfr_i && !mem_latch_i) begin
            mem_rdata_o = ~mem[{mem_sfr_i, mem_addr_i}];
        end else begin
            mem_rdata_o = mem[{mem_sfr_i, mem_addr_i}];
        end
    end
    always @(posedge ref_clk_i) begin
        if (mem_rd_i) begin
            last <= mem_rdata_o;
        end
        if (mem_wr_i) begin
            mem[{mem_sfr_i, mem_addr_i}] <= mem_wdata_i;
        end
    end
endmodule // nxe_mem_model
`default_nettype wire

// ### tb/nxe_exec_checker.sv
// Port level assertions for the executor
`timescale 1ns/1ps
`default_nettype none
module nxe_exec_checker (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic start_i,
    input wire logic [7:0] opcode_i,
    input wire logic [7:0] operand1_i,
    input wire logic [7:0] operand2_i,
    input wire logic [1:0] bank_i,
    input wire logic [7:0] acc_i,
    input wire logic [7:0] mem_rdata_i,
    input wire logic mem_rd_o,
    input wire logic mem_wr_o,
    input wire logic [7:0] mem_addr_o,
    input wire logic mem_sfr_o,
    input wire logic mem_latch_o,
    input wire logic [7:0] mem_wdata_o,
    input wire logic acc_wr_o,
    input wire logic [7:0] acc_wdata_o,
    input wire logic parity_wr_o,
    input wire logic parity_o,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic unsupported_o,
    input wire logic [1:0] length_o,
    input wire logic [1:0] cycles_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b_i);
    logic go;
    logic sup;
    assign go = start_i && !busy_o;
    assign sup = ((opcode_i & 8'hfe) == 8'hd6) ||
        ((opcode_i & 8'hf8) == 8'h68) || (opcode_i inside {[8'h62:8'h67]});
    property p_swap;
        go && (opcode_i & 8'hfe) == 8'hd6 |=> !mem_sfr_o ##2
            done_o && mem_wr_o && acc_wr_o && !parity_wr_o;
    endproperty
    a_swap: assert property (p_swap) else $error("swap timing wrong");
    property p_reg;
        go && (opcode_i & 8'hf8) == 8'h68 |=> mem_rd_o &&
            mem_addr_o == {3'h0, $past(bank_i), $past(opcode_i[2:0])} ##1
            done_o && acc_wdata_o == ($past(acc_i, 2) ^ $past(mem_rdata_i));
    endproperty
    a_reg: assert property (p_reg) else $error("register form wrong");
    property p_imm;
        go && opcode_i == 8'h64 |=> busy_o && !mem_rd_o ##1 done_o &&
            acc_wdata_o == ($past(acc_i, 2) ^ $past(operand1_i, 2));
    endproperty
    a_imm: assert property (p_imm) else $error("immediate form wrong");
    property p_par;
        parity_wr_o |-> acc_wr_o && parity_o == ^acc_wdata_o;
    endproperty
    a_par: assert property (p_par) else $error("parity wrong");
    property p_dimm;
        go && opcode_i == 8'h63 |=> mem_rd_o && mem_latch_o &&
            length_o == 2'h3 && cycles_o == 2'h2 ##1 done_o && mem_wr_o &&
            !acc_wr_o && mem_wdata_o == ($past(mem_rdata_i) ^ $past(operand2_i, 2));
    endproperty
    a_dimm: assert property (p_dimm) else $error("direct imm wrong");
    property p_dacc;
        go && opcode_i == 8'h62 |=> mem_rd_o && mem_latch_o &&
            mem_addr_o == $past(operand1_i) ##1 done_o && !parity_wr_o &&
            mem_wdata_o == ($past(mem_rdata_i) ^ $past(acc_i, 2));
    endproperty
    a_dacc: assert property (p_dacc) else $error("direct acc wrong");
    property p_bad;
        go && !sup |=> unsupported_o && !mem_rd_o && length_o == 2'h0;
    endproperty
    a_bad: assert property (p_bad) else $error("unsupported wrong");
    property p_busy;
        go && sup |=> busy_o [*1] ##0 !done_o;
    endproperty
    a_busy: assert property (p_busy) else $error("busy wrong");
endmodule // nxe_exec_checker
bind nxe_exec nxe_exec_checker u_chk (.*);
`default_nettype wire

// ### tb/testbench.sv
// Directed testbench for the executor
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk_i = 0, rst_b_i = 0, start_i = 0;
    logic [7:0] opcode_i = 0, operand1_i = 0, operand2_i = 0, acc_i = 0;
    logic [1:0] bank_i = 0;
    logic [7:0] mem_rdata_i, mem_addr_o, mem_wdata_o, acc_wdata_o;
    logic mem_rd_o, mem_wr_o, mem_sfr_o, mem_latch_o, acc_wr_o;
    logic parity_wr_o, parity_o, busy_o, done_o, unsupported_o;
    logic [1:0] length_o, cycles_o;
    logic saw, w_acc, w_par;
    int err_total = 0, comparisons = 0, cyc = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    nxe_exec DUT (.*);
    nxe_mem_model mdl (.ref_clk_i(ref_clk_i), .mem_rd_i(mem_rd_o),
        .mem_wr_i(mem_wr_o), .mem_addr_i(mem_addr_o), .mem_sfr_i(mem_sfr_o),
        .mem_latch_i(mem_latch_o), .mem_wdata_i(mem_wdata_o),
        .mem_rdata_o(mem_rdata_i));
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        comparisons++;
        if (e !== g) begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            err_total++;
        end
    endtask
    task automatic run(logic [7:0] op, o1, o2, logic [1:0] bk, logic [7:0] a);
        @(negedge ref_clk_i);
        start_i = 1; opcode_i = op; operand1_i = o1;
        operand2_i = o2; bank_i = bk; acc_i = a;
        @(negedge ref_clk_i);
        start_i = 0;
        saw = 0;
        repeat (6) begin
            if (!saw && (done_o === 1 || unsupported_o === 1)) begin
                saw = 1; w_acc = acc_wr_o; w_par = parity_wr_o;
            end
            if (!saw) @(negedge ref_clk_i);
        end
        chk("completion", 1, saw);
    endtask
    task automatic t_swap;
        mdl.mem[9'h009] = 8'h20; mdl.mem[9'h020] = 8'h75;
        run(8'hd7, 0, 0, 2'h1, 8'h36);
        chk("swap acc", 8'h35, acc_wdata_o);
        chk("swap flags", 8'h02, {w_acc, w_par});
        chk("swap len", 1, length_o);
        @(negedge ref_clk_i);
        chk("swap mem", 8'h76, mdl.mem[9'h020]);
        mdl.mem[9'h000] = 8'h50;
        mdl.mem[9'h050] = 8'h9a;
        run(8'hd6, 0, 0, 2'h0, 8'h4c);
        chk("swap r0 acc", 8'h4a, acc_wdata_o);
        @(negedge ref_clk_i);
        chk("swap r0 mem", 8'h9c, mdl.mem[9'h050]);
        $display("test swap done");
    endtask
    task automatic t_reg;
        logic [7:0] e;
        for (int r = 0; r < 8; r++) begin
            mdl.mem[9'h010 + r] = 8'haa ^ r[7:0];
            e = 8'hc3 ^ 8'haa ^ r[7:0];
            run(8'h68 | r[7:0], 0, 0, 2'h2, 8'hc3);
            chk("reg acc", e, acc_wdata_o);
            chk("reg par", {7'h0, ^e}, {7'h0, parity_o});
            chk("reg len", 8'h35,
                {2'h0, w_acc, w_par, length_o, cycles_o});
        end
        $display("test reg done");
    endtask
    task automatic t_acc;
        mdl.mem[9'h040] = 8'h5a; mdl.mem[9'h000] = 8'h41;
        mdl.mem[9'h041] = 8'hff;
        run(8'h65, 8'h40, 0, 2'h0, 8'h0f);
        chk("dir acc", 8'h55, acc_wdata_o);
        chk("dir len", 2, length_o);
        run(8'h66, 0, 0, 2'h0, 8'h0f);
        chk("ind acc", 8'hf0, acc_wdata_o);
        chk("ind par", 0, parity_o);
        mdl.mem[9'h019] = 8'h22;
        mdl.mem[9'h022] = 8'h3c;
        run(8'h67, 0, 0, 2'h3, 8'h0f);
        chk("ind r1 acc", 8'h33, acc_wdata_o);
        run(8'h64, 8'h81, 0, 2'h0, 8'h01);
        chk("imm acc", 8'h80, acc_wdata_o);
        chk("imm len", 8'h21, {length_o, 2'h0, cycles_o});
        $display("test acc forms done");
    endtask
    task automatic t_dir;
        mdl.mem[9'h190] = 8'h0f; mdl.mem[9'h030] = 8'hf0;
        run(8'h63, 8'h90, 8'h31, 2'h0, 8'hff);
        chk("dimm len", 8'h32, {length_o, 2'h0, cycles_o});
        chk("dimm flags", 0, {w_acc, w_par});
        @(negedge ref_clk_i);
        chk("port latch", 8'h3e, mdl.mem[9'h190]);
        run(8'h62, 8'h30, 0, 2'h0, 8'h3c);
        chk("dacc len", 8'h21, {length_o, 2'h0, cycles_o});
        chk("dacc flags", 0, {w_acc, w_par});
        @(negedge ref_clk_i);
        chk("dacc mem", 8'hcc, mdl.mem[9'h030]);
        $display("test direct done");
    endtask
    task automatic t_rst;
        @(negedge ref_clk_i);
        start_i = 1;
        opcode_i = 8'hd6;
        bank_i = 2'h0;
        @(negedge ref_clk_i);
        start_i = 0;
        rst_b_i = 0;
        @(negedge ref_clk_i);
        chk("rst busy", 0, {busy_o, length_o});
        rst_b_i = 1;
        @(negedge ref_clk_i);
        chk("rst idle", 0, {mem_rd_o, mem_wr_o, done_o, busy_o});
        $display("test reset done");
    endtask
    task automatic t_bad;
        run(8'ha5, 0, 0, 2'h0, 8'h00);
        chk("bad flag", 1, unsupported_o);
        chk("bad len", 0, length_o);
        $display("test unsupported done");
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc > 2000) begin
            err_total++;
            stop_test();
        end
    end
    initial begin
        repeat (2) @(negedge ref_clk_i);
        rst_b_i = 1;
        t_swap();
        t_reg();
        t_acc();
        t_dir();
        t_rst();
        t_bad();
        stop_test();
    end
endmodule // testbench
`default_nettype wire
